/* File: urxb_pkg.sv */
// package for the serial receive buffer and status block
package urxb_pkg;

    // register byte offsets
    localparam logic [7:0] URXB_OFF_STATUS = 8'h00;
    localparam logic [7:0] URXB_OFF_CONTROL = 8'h04;
    localparam logic [7:0] URXB_OFF_FORMAT = 8'h08;
    localparam logic [7:0] URXB_OFF_DATA = 8'h0c;
    localparam logic [7:0] URXB_OFF_BAUD = 8'h10;

    // serial_status_reg fields
    localparam int URXB_ST_RXDONE = 7;
    localparam int URXB_ST_FRMERR = 4;
    localparam int URXB_ST_OVRRUN = 3;
    localparam int URXB_ST_PARERR = 2;
    // serial_control_reg fields
    localparam int URXB_CT_IRQEN = 7;
    localparam int URXB_CT_RXON = 4;
    localparam int URXB_CT_NINTH = 1;
    // serial_format_reg fields
    localparam int URXB_FM_PAREN = 5;
    localparam int URXB_FM_PARODD = 4;
    localparam int URXB_FM_STOP2 = 3;
    localparam int URXB_FM_CSIZE = 0;

    // reset values
    localparam logic [2:0] URXB_RST_CSIZE = 3'h3;
    localparam logic [15:0] URXB_RST_BAUD = 16'h0000;

    // receive sampling
    localparam logic [4:0] URXB_SMP_FIRST = 5'h01;
    localparam logic [4:0] URXB_SMP_LAST = 5'h10;
    localparam logic [4:0] URXB_SMP_V0 = 5'h08;
    localparam logic [4:0] URXB_SMP_V1 = 5'h09;
    localparam logic [4:0] URXB_SMP_V2 = 5'h0a;
    localparam logic [1:0] URXB_FIFO_FULL = 2'h2;
    localparam logic [2:0] URXB_CSIZE_NINE = 3'h7;

    typedef enum logic [2:0] {
        URXB_IDLE,
        URXB_START,
        URXB_DATA,
        URXB_PAR,
        URXB_STOP
    } urxb_state_t;

    typedef struct packed {
        logic [8:0] data;
        logic frm_err;
        logic ovr;
        logic par_err;
    } urxb_entry_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } urxb_ahb_req_t;

endpackage

/* File: urxb_rx_buffer.sv */
// serial receiver with two-entry receive buffer, status and ahb-lite registers
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - data read advances buffer, status follows
// - receive-complete set while unread data remain
// - receiver disable flushes buffer, clears flag
// - interrupt requested while flag and enables set
// - error flags stored with their frame
// - writes to error flag bits ignored
// - error flags raise no interrupt
// - frame error set on zero stop bit
// - only first stop bit checked
// - overrun when full, waiting, new start
// - overrun cleared on successful buffer transfer
// - parity computed and compared when enabled
// - parity error only if enabled, mismatched
// - parity error reads zero when disabled
// - disable abandons reception, releases pin
// - shift to first stop, ignore second
// - unused high data bits read zero
// - enabled receiver takes over input pin
// - majority vote of samples 8,9,10
module urxb_rx_buffer (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire urxb_pkg::urxb_ahb_req_t ahb_req,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // serial line and pin control
    input wire logic rxd,
    output logic rxd_sel,
    // interrupt
    input wire logic global_irq_en,
    output logic rx_irq
);
    import urxb_pkg::*;

    typedef struct packed {
        urxb_state_t st;
        logic [15:0] pre;
        logic [4:0] smp;
        logic [1:0] vote;
        logic [3:0] bit_idx;
        logic [8:0] shf;
        logic par_acc;
        logic par_err;
        logic wait_v;
        urxb_entry_t wait_e;
        logic ovr_pend;
        urxb_entry_t [1:0] fifo;
        logic rd_ptr;
        logic [1:0] cnt;
        logic rx_en;
        logic irq_en;
        logic par_en;
        logic par_odd;
        logic stop2;
        logic [2:0] csize;
        logic [15:0] baud;
        logic wr_pend;
        logic [7:0] waddr;
        logic [31:0] rdata;
        logic ready;
        logic resp;
        logic irq;
        logic pin_sel;
        logic rxd_prev;
    } urxb_regs_t;

    urxb_regs_t q;
    urxb_regs_t d;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [3:0] last_bit(input logic [2:0] csize);
        unique case (csize)
            3'h0: last_bit = 4'h4;
            3'h1: last_bit = 4'h5;
            3'h2: last_bit = 4'h6;
            URXB_CSIZE_NINE: last_bit = 4'h8;
            default: last_bit = 4'h7;
        endcase
    endfunction

    function automatic logic [31:0] read_reg(input urxb_regs_t s, input logic [7:0] a);
        urxb_entry_t head;
        head = s.fifo[s.rd_ptr];
        read_reg = 32'h0;
        unique case (a)
            URXB_OFF_STATUS: begin
                read_reg[URXB_ST_RXDONE] = (s.cnt != 2'h0);
                read_reg[URXB_ST_FRMERR] = head.frm_err;
                read_reg[URXB_ST_OVRRUN] = head.ovr;
                read_reg[URXB_ST_PARERR] = head.par_err & s.par_en;
            end
            URXB_OFF_CONTROL: begin
                read_reg[URXB_CT_IRQEN] = s.irq_en;
                read_reg[URXB_CT_RXON] = s.rx_en;
                read_reg[URXB_CT_NINTH] = head.data[8];
            end
            URXB_OFF_FORMAT: begin
                read_reg[URXB_FM_PAREN] = s.par_en;
                read_reg[URXB_FM_PARODD] = s.par_odd;
                read_reg[URXB_FM_STOP2] = s.stop2;
                read_reg[URXB_FM_CSIZE +: 3] = s.csize;
            end
            URXB_OFF_DATA: read_reg[7:0] = head.data[7:0];
            URXB_OFF_BAUD: read_reg[15:0] = s.baud;
            default: read_reg = 32'h0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic take;
        logic do_read;
        logic tick;
        logic [4:0] nsmp;
        logic bitv;
        logic pushed;
        logic frame_done;
        urxb_entry_t done_e;
        take = 1'b0;
        do_read = 1'b0;
        tick = 1'b0;
        nsmp = q.smp;
        bitv = 1'b0;
        pushed = 1'b0;
        frame_done = 1'b0;
        done_e = '0;
        d = q;
        d.ready = 1'b1;
        d.resp = 1'b0;
        d.rxd_prev = rxd;

        // bus data phase of a write
        d.wr_pend = 1'b0;
        if (q.wr_pend) begin
            unique case (q.waddr)
                URXB_OFF_CONTROL: begin
                    d.irq_en = ahb_req.hwdata[URXB_CT_IRQEN];
                    d.rx_en = ahb_req.hwdata[URXB_CT_RXON];
                end
                URXB_OFF_FORMAT: begin
                    d.par_en = ahb_req.hwdata[URXB_FM_PAREN];
                    d.par_odd = ahb_req.hwdata[URXB_FM_PARODD];
                    d.stop2 = ahb_req.hwdata[URXB_FM_STOP2];
                    d.csize = ahb_req.hwdata[URXB_FM_CSIZE +: 3];
                end
                URXB_OFF_BAUD: d.baud = ahb_req.hwdata[15:0];
                // status flags are not writable
                default: ;
            endcase
        end

        // bus address phase
        take = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
        if (take) begin
            if (ahb_req.hwrite) begin
                d.wr_pend = 1'b1;
                d.waddr = ahb_req.haddr[7:0];
            end else begin
                d.rdata = read_reg(q, ahb_req.haddr[7:0]);
                do_read = (ahb_req.haddr[7:0] == URXB_OFF_DATA);
            end
        end

        // data read pops the head entry, empty read is ignored
        if (do_read && q.cnt != 2'h0) begin
            d.rd_ptr = ~q.rd_ptr;
            d.cnt = q.cnt - 2'h1;
        end

        // waiting frame moves in when room appears
        if (q.wait_v && d.cnt != URXB_FIFO_FULL) begin
            d.fifo[d.rd_ptr ^ d.cnt[0]] = q.wait_e;
            d.fifo[d.rd_ptr ^ d.cnt[0]].ovr = q.ovr_pend;
            d.ovr_pend = 1'b0;
            d.cnt = d.cnt + 2'h1;
            d.wait_v = 1'b0;
            pushed = 1'b1;
        end

        // sample clock
        if (q.st != URXB_IDLE) begin
            if (q.pre >= q.baud) begin
                d.pre = 16'h0;
                tick = 1'b1;
            end else begin
                d.pre = q.pre + 16'h1;
            end
        end

        // start detection
        if (q.st == URXB_IDLE && q.rx_en && q.rxd_prev && !rxd) begin
            d.st = URXB_START;
            d.smp = URXB_SMP_FIRST;
            d.pre = 16'h0;
            d.vote = 2'h0;
            if (q.wait_v && q.cnt == URXB_FIFO_FULL) begin
                d.ovr_pend = 1'b1;
            end
        end

        // bit recovery
        if (tick) begin
            nsmp = (q.smp == URXB_SMP_LAST) ? URXB_SMP_FIRST : q.smp + 5'h1;
            d.smp = nsmp;
            if (nsmp == URXB_SMP_V0 || nsmp == URXB_SMP_V1) begin
                d.vote = {q.vote[0], rxd};
            end
            if (nsmp == URXB_SMP_V2) begin
                bitv = (q.vote[1] & q.vote[0]) | (q.vote[1] & rxd) | (q.vote[0] & rxd);
                unique case (q.st)
                    URXB_START: begin
                        if (bitv) begin
                            d.st = URXB_IDLE;
                        end else begin
                            d.st = URXB_DATA;
                            d.bit_idx = 4'h0;
                            d.shf = 9'h0;
                            d.par_acc = 1'b0;
                        end
                    end
                    URXB_DATA: begin
                        d.shf[q.bit_idx] = bitv;
                        d.par_acc = q.par_acc ^ bitv;
                        d.bit_idx = q.bit_idx + 4'h1;
                        if (q.bit_idx == last_bit(q.csize)) begin
                            d.st = q.par_en ? URXB_PAR : URXB_STOP;
                        end
                        d.par_err = 1'b0;
                    end
                    URXB_PAR: begin
                        d.par_err = q.par_en & ((q.par_acc ^ bitv) != q.par_odd);
                        d.st = URXB_STOP;
                    end
                    URXB_STOP: begin
                        frame_done = 1'b1;
                        done_e.data = q.shf;
                        done_e.frm_err = ~bitv;
                        done_e.par_err = q.par_err;
                        done_e.ovr = 1'b0;
                        d.st = URXB_IDLE;
                    end
                    default: d.st = URXB_IDLE;
                endcase
            end
        end

        // finished frame enters buffer, waits, or is lost
        if (frame_done) begin
            if (!pushed && !q.wait_v && d.cnt != URXB_FIFO_FULL) begin
                d.fifo[d.rd_ptr ^ d.cnt[0]] = done_e;
                d.fifo[d.rd_ptr ^ d.cnt[0]].ovr = d.ovr_pend;
                d.ovr_pend = 1'b0;
                d.cnt = d.cnt + 2'h1;
            end else if (!d.wait_v) begin
                d.wait_v = 1'b1;
                d.wait_e = done_e;
            end
        end

        // disabled receiver drops everything at once
        if (!d.rx_en) begin
            d.cnt = 2'h0;
            d.wait_v = 1'b0;
            d.ovr_pend = 1'b0;
            d.st = URXB_IDLE;
            d.pre = 16'h0;
        end

        d.pin_sel = d.rx_en;
        // only receive-complete drives the request
        d.irq = d.irq_en & global_irq_en & (d.cnt != 2'h0);
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.st <= URXB_IDLE;
            q.csize <= URXB_RST_CSIZE;
            q.baud <= URXB_RST_BAUD;
            q.ready <= 1'b1;
            q.rxd_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign hrdata = q.rdata;
    assign hreadyout = q.ready;
    assign hresp = q.resp;
    assign rxd_sel = q.pin_sel;
    assign rx_irq = q.irq;

endmodule
`default_nettype wire

/* File: urxb_rx_buffer_asserts.sv */
// port checker for the receive buffer block
`timescale 1ns/10ps
`default_nettype none
module urxb_rx_buffer_asserts (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire urxb_pkg::urxb_ahb_req_t ahb_req,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // line and interrupt
    input wire logic rxd,
    input wire logic rxd_sel,
    input wire logic global_irq_en,
    input wire logic rx_irq
);
    import urxb_pkg::*;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic take;
    assign take = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
    sequence ctl_wr;
        take && ahb_req.hwrite && ahb_req.haddr[7:0] == URXB_OFF_CONTROL;
    endsequence
    sequence calm;
        (global_irq_en && !take) [*3];
    endsequence
    chk_bus_okay:
        assert property (!hresp && hreadyout) else $error("bus answer not okay");
    chk_rdata_hold:
        assert property (!(take && !ahb_req.hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    chk_receiver_enable_bit_write:
        assert property (ctl_wr ##1 1'b1 |=> rxd_sel == $past(ahb_req.hwdata[URXB_CT_RXON]))
        else $error("receiver enable not taken");
    chk_irq_gated:
        assert property (!global_irq_en |=> !rx_irq) else $error("irq without enable");
    chk_irq_rise:
        assert property ($rose(rx_irq) |-> rxd_sel) else $error("irq while off");
    chk_irq_flush:
        assert property ($fell(rxd_sel) |-> ##[0:2] !rx_irq) else $error("irq after flush");
    chk_off_quiet:
        assert property (!rxd_sel [*3] |-> !rx_irq) else $error("irq while disabled");
    chk_irq_stays:
        assert property (calm ##0 rx_irq |=> rx_irq) else $error("irq dropped");
endmodule
bind urxb_rx_buffer urxb_rx_buffer_asserts u_chk (.hclk(hclk), .hresetn(hresetn),
    .ahb_req(ahb_req), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd),
    .rxd_sel(rxd_sel), .global_irq_en(global_irq_en), .rx_irq(rx_irq));
`default_nettype wire

/* File: urxb_line_model.sv */
// remote serial transmitter on the receive line
`timescale 1ns/10ps
`default_nettype none
module urxb_line_model (
    // clock and line
    input wire logic hclk,
    output logic rxd
);
    initial rxd = 1'b1;
    task automatic bit_out(input logic b);
        rxd <= b;
        repeat (16) @(posedge hclk);
    endtask
    // start, data lsb first, parity if par >= 0, one stop
    task automatic send(input logic [8:0] d, input int nb, input int par, input logic stp);
        @(posedge hclk);
        bit_out(1'b0);
        for (int i = 0; i < nb; i++) begin
            bit_out(d[i]);
        end
        if (par >= 0) begin
            bit_out(par[0]);
        end
        bit_out(stp);
        rxd <= 1'b1;
    endtask
endmodule
`default_nettype wire

/* File: test_uart_receive_buffer_status.sv */
// self-checking bench for the receive buffer block
`timescale 1ns/10ps
`default_nettype none
module test_uart_receive_buffer_status;
    import urxb_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic gie = 1'b0;
    logic par_en = 1'b0;
    logic par_odd = 1'b0;
    logic [31:0] hrdata;
    logic [31:0] r;
    logic [31:0] seed = 32'h51461524;
    logic hreadyout, hresp, rxd, rxd_sel, rx_irq;
    urxb_ahb_req_t req = '0;
    urxb_ahb_req_t bus_req;
    logic [11:0] q[$];
    int mismatches = 0;
    int tests_run = 0;
    int nb;
    //////////////////////////////
    always #10 hclk = ~hclk;
    always_comb begin
        bus_req = req;
        bus_req.hready = hreadyout;
    end
    urxb_rx_buffer u_dut (.hclk(hclk), .hresetn(hresetn), .ahb_req(bus_req), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .rxd_sel(rxd_sel),
        .global_irq_en(gie), .rx_irq(rx_irq));
    urxb_line_model u_line (.hclk(hclk), .rxd(rxd));
    //////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        req <= '{1'b1, {24'h0, a}, 2'h2, wr, 3'h2, 32'h0, 1'b1};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        req.htrans <= 2'h0;
        req.hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic stat();
        bus(1'b0, URXB_OFF_STATUS, 32'h0);
        check(r[URXB_ST_RXDONE], q.size() != 0);
        check(rx_irq, gie && q.size() != 0);
    endtask
    task automatic rx(input logic [8:0] d, input logic bad, input logic stp);
        logic [8:0] m;
        m = d & ((9'h1 << nb) - 9'h1);
        u_line.send(m, nb, par_en ? int'(^m ^ par_odd ^ bad) : -1, stp);
        repeat (3) @(posedge hclk);
        q.push_back({1'b0, ~stp, bad & par_en, m});
    endtask
    task automatic pop();
        logic [11:0] e;
        e = q.pop_front();
        bus(1'b1, URXB_OFF_STATUS, 32'h0);
        bus(1'b0, URXB_OFF_STATUS, 32'h0);
        check({r[URXB_ST_FRMERR], r[URXB_ST_OVRRUN], r[URXB_ST_PARERR]}, {e[10], e[11], e[9] & par_en});
        bus(1'b0, URXB_OFF_CONTROL, 32'h0);
        check(r[URXB_CT_NINTH], e[8]);
        bus(1'b0, URXB_OFF_DATA, 32'h0);
        check(r, {24'h0, e[7:0]});
        stat();
    endtask
    //////////////////////////////
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, URXB_OFF_CONTROL, 32'h0);
        check(r, 32'h0);
        bus(1'b0, URXB_OFF_FORMAT, 32'h0);
        check(r[2:0], URXB_RST_CSIZE);
        bus(1'b0, 8'h14, 32'h0);
        check(r, 32'h0);
        bus(1'b1, URXB_OFF_BAUD, 32'h0000abcd);
        bus(1'b0, URXB_OFF_BAUD, 32'h0);
        check(r, 32'h0000abcd);
        bus(1'b1, URXB_OFF_BAUD, 32'h0);
        bus(1'b1, URXB_OFF_CONTROL, 32'h90);
        @(posedge hclk);
        check(rxd_sel, 1'b1);
        // sizes 5, 6, 7, 9 with and without parity
        for (int k = 0; k < 12; k++) begin
            seed = lfsr(seed);
            nb = (k % 4 == 3) ? 9 : 5 + k % 4;
            par_en = k >= 4;
            par_odd = seed[0];
            gie <= seed[1];
            bus(1'b1, URXB_OFF_FORMAT, {par_en, par_odd, seed[2], nb == 9 ? 3'h7 : 3'(nb - 5)});
            rx(seed[8:0], seed[3], seed[4]);
            rx(seed[17:9], seed[5], 1'b1);
            stat();
            if (k == 11) begin
                par_en = 1'b0;
                bus(1'b1, URXB_OFF_FORMAT, 32'h3);
            end
            pop();
            pop();
            bus(1'b0, URXB_OFF_DATA, 32'h0);
            stat();
        end
        // four frames unread, fourth start overruns, fourth frame lost
        nb = 8;
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            rx(seed[8:0], 1'b0, 1'b1);
        end
        void'(q.pop_back());
        q[2][11] = 1'b1;
        pop();
        pop();
        pop();
        // disable in mid-frame
        nb = 8;
        rx(9'h5a, 1'b0, 1'b1);
        fork
            rx(9'h3c, 1'b0, 1'b1);
            begin
                repeat (60) @(posedge hclk);
                bus(1'b1, URXB_OFF_CONTROL, 32'h0);
            end
        join
        q.delete();
        check(rxd_sel, 1'b0);
        bus(1'b1, URXB_OFF_CONTROL, 32'h90);
        stat();
        rx(9'h66, 1'b0, 1'b1);
        pop();
        wrap_up();
    end
    initial begin
        repeat (60000) @(posedge hclk);
        mismatches++;
        wrap_up();
    end
endmodule
`default_nettype wire
